// ---- hdl/stepper_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef STEPPER_REGS_SVH
`define STEPPER_REGS_SVH

`define OFS_CTRL     12'h000
`define OFS_CMD      12'h004
`define OFS_STATUS   12'h008
`define OFS_RATE     12'h00C
`define OFS_ARG_LO   12'h010
`define OFS_ARG_HI   12'h014
`define OFS_POS_LO   12'h018
`define OFS_POS_HI   12'h01C
`define OFS_MARK_LO  12'h020
`define OFS_MARK_HI  12'h024

`define CTRL_MODE_LSB   0
`define CTRL_PULSE_BIT  2
`define CTRL_RESET      32'h0000_0000
`define RATE_RESET      32'h0000_C350

`define POS_W           48
`define STEP_GAP_NS     100000
`define CLK_PERIOD_NS   20
`define STEP_GAP_CYC    (`STEP_GAP_NS / `CLK_PERIOD_NS)

`endif

// ---- hdl/stepper_pkg.sv ----
// types shared by the stepper sequencer files
package stepper_pkg;

  typedef enum logic [1:0] {
    MODE_TWO  = 2'h0,
    MODE_WAVE = 2'h1,
    MODE_HALF = 2'h2
  } step_mode_t;

  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_ABS      = 4'h1,
    CMD_ABS_STOP = 4'h2,
    CMD_REL      = 4'h3,
    CMD_HOME     = 4'h4,
    CMD_MARK     = 4'h5,
    CMD_SET_HOME = 4'h6,
    CMD_SET_MARK = 4'h7,
    CMD_PIN_ABS  = 4'h8,
    CMD_PIN_REL  = 4'h9,
    CMD_PIN_CW   = 4'hA,
    CMD_PIN_CCWZ = 4'hB,
    CMD_PIN_CWM  = 4'hC,
    CMD_STOP     = 4'hD,
    CMD_READPOS  = 4'hE
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_STEP = 3'b100
  } run_state_t;

endpackage : stepper_pkg

// ---- hdl/coil_if.sv ----
`timescale 1ns/100ps
// step request and coil pattern between sequencer and phase table
interface coil_if;
  logic       step;
  logic       cw;
  logic [1:0] mode;
  logic [3:0] coils;

  modport ctrl (output step, output cw, output mode, input coils);
  modport table_side (input step, input cw, input mode, output coils);
endinterface : coil_if

// ---- hdl/coil_phase.sv ----
`timescale 1ns/100ps
// coil pattern table and phase index
module coil_phase
  import stepper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  coil_if.table_side cif
);

  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic [3:0] coils_q;
  logic [3:0] pat;
  logic       half;
  logic [2:0] last;

  // half step uses all eight entries, full modes the first four
  assign half = (cif.mode == MODE_HALF);
  assign last = half ? 3'h7 : 3'h3;

  // pattern bits: coil_one is msb
  function automatic logic [3:0] lookup(input logic [1:0] m,
                                         input logic [2:0] i);
    logic [3:0] r;
    r = 4'h0;
    unique case (m)
      MODE_WAVE: r = 4'h8 >> i[1:0];
      MODE_HALF: begin
        unique case (i)
          3'h0: r = 4'h8;
          3'h1: r = 4'hC;
          3'h2: r = 4'h4;
          3'h3: r = 4'h6;
          3'h4: r = 4'h2;
          3'h5: r = 4'h3;
          3'h6: r = 4'h1;
          default: r = 4'h9;
        endcase
      end
      default: begin
        unique case (i[1:0])
          2'h0: r = 4'hC;
          2'h1: r = 4'h6;
          2'h2: r = 4'h3;
          default: r = 4'h9;
        endcase
      end
    endcase
    return r;
  endfunction : lookup

  // clockwise forward, counter-clockwise backward, wrapping
  assign idx_d = !cif.step ? (idx_q > last ? 3'h0 : idx_q) :
                 cif.cw ? (idx_q >= last ? 3'h0 : idx_q + 3'h1) :
                 (idx_q == 3'h0 || idx_q > last) ? last : idx_q - 3'h1;
  assign pat = lookup(cif.mode, idx_d);

  // index held when idle so motion resumes at the neighbour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q   <= 3'h0;
      coils_q <= 4'h0;
    end else if (ce) begin
      idx_q   <= idx_d;
      coils_q <= pat;
    end
  end

  assign cif.coils = coils_q;

  a_wave_one_coil: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cif.mode == MODE_WAVE && ce) |=> $onehot(coils_q))
    else $error("wave mode coil not one-hot");

endmodule : coil_phase

// ---- hdl/stepper_seq.sv ----
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
// stepper sequencer top with apb register slave
`include "stepper_regs.svh"
module stepper_seq
  import stepper_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        step_or_ccw_stop_input,
  input  wire logic        direction_or_cw_stop_input,
  output logic             coil_one,
  output logic             coil_two,
  output logic             coil_three,
  output logic             coil_four,
  output logic             busy_n
);

  localparam int PW = `POS_W;
  localparam logic [PW-1:0] POS_ONE = {{(PW-1){1'b0}}, 1'b1};

  coil_if cif ();

  coil_phase u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .cif     (cif)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0]   ctrl_q;
  logic [31:0]   rate_q;
  logic [PW-1:0] arg_q;
  logic [PW-1:0] pos_q;
  logic [PW-1:0] mark_q;
  logic [PW-1:0] target_q;
  logic [PW-1:0] snap_q;
  logic [31:0]   prdata_q;
  logic [31:0]   tmr_q;
  logic          dir_q;
  logic          run_q;
  logic          stop_en_q;
  logic          endless_q;
  logic [1:0]    after_q;
  logic          step_in_q;
  logic          stopped_q;
  run_state_t    state_q;

  wire logic wr_en = psel & penable & pwrite & ce;
  wire logic rd_en = psel & ~penable & ~pwrite & ce;
  wire logic [1:0] mode = ctrl_q[`CTRL_MODE_LSB +: 2];
  wire logic pulse_mode = ctrl_q[`CTRL_PULSE_BIT];

  // upper read word: bits 47:32 sign-extended to a full bus word
  function automatic logic [31:0] sext(input logic [PW-1:0] v);
    return {{16{v[PW-1]}}, v[PW-1:32]};
  endfunction : sext

  // one step on the counter, full width so no carry is dropped
  function automatic logic [PW-1:0] step_pos(input logic [PW-1:0] p,
                                             input logic          cw);
    return cw ? p + POS_ONE : p - POS_ONE;
  endfunction : step_pos

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic hit_ctrl  = paddr == `OFS_CTRL;
  wire logic hit_cmd   = paddr == `OFS_CMD;
  wire logic hit_rate  = paddr == `OFS_RATE;
  wire logic hit_arglo = paddr == `OFS_ARG_LO;
  wire logic hit_arghi = paddr == `OFS_ARG_HI;
  wire logic known = hit_ctrl | hit_cmd | hit_rate | hit_arglo |
                     hit_arghi | paddr == `OFS_STATUS |
                     paddr == `OFS_POS_LO | paddr == `OFS_POS_HI |
                     paddr == `OFS_MARK_LO | paddr == `OFS_MARK_HI;
  wire cmd_t cmd = cmd_t'(pwdata[3:0]);
  wire logic cmd_go = wr_en & hit_cmd;

  // one-cycle access phase, unmapped addresses error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // stop pins are active low, pulled high when idle
  wire logic ccw_stop = ~step_or_ccw_stop_input;
  wire logic cw_stop  = ~direction_or_cw_stop_input;
  wire logic pin_hit = stop_en_q &
                       ((ccw_stop & ~dir_q) | (cw_stop & dir_q) |
                        (~endless_q & (ccw_stop | cw_stop)));
  wire logic arrived = ~endless_q & (pos_q == target_q);
  wire logic pulse_fall = pulse_mode & step_in_q &
                          ~step_or_ccw_stop_input & ~run_q;
  wire logic tick = (state_q == ST_WAIT) & (tmr_q == 32'h0);
  wire logic do_step = (tick & ~arrived & ~pin_hit) | pulse_fall;
  wire logic step_cw = pulse_fall ? direction_or_cw_stop_input : dir_q;

  // command decode
  wire logic [PW-1:0] rel_tgt = pos_q + arg_q;
  wire logic start_abs = cmd_go & (cmd == CMD_ABS | cmd == CMD_ABS_STOP |
                                   cmd == CMD_PIN_ABS);
  wire logic start_rel = cmd_go & (cmd == CMD_REL | cmd == CMD_PIN_REL);
  wire logic start_home = cmd_go & cmd == CMD_HOME;
  wire logic start_mark = cmd_go & cmd == CMD_MARK;
  wire logic start_free = cmd_go & (cmd == CMD_PIN_CW |
                                    cmd == CMD_PIN_CCWZ |
                                    cmd == CMD_PIN_CWM);
  wire logic start_any = ~pulse_mode & ~run_q &
                         (start_abs | start_rel | start_home |
                          start_mark | start_free);
  wire logic [PW-1:0] new_tgt =
      start_abs  ? arg_q :
      start_rel  ? rel_tgt :
      start_mark ? mark_q : {PW{1'b0}};
  wire logic new_stop = cmd == CMD_ABS_STOP | cmd == CMD_PIN_ABS |
                        cmd == CMD_PIN_REL | start_free;
  wire logic new_dir = start_free ? (cmd != CMD_PIN_CCWZ) :
                       ($signed(new_tgt) > $signed(pos_q));
  wire logic finish = run_q & ((tick & (arrived | pin_hit)) |
                               (cmd_go & cmd == CMD_STOP));

  ////////////////////////////////////////////////////////////////////////
  // configuration and argument registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      rate_q <= `RATE_RESET;
      arg_q  <= '0;
    end else if (wr_en) begin
      if (hit_ctrl)  ctrl_q <= pwdata;
      if (hit_rate)  rate_q <= pwdata;
      if (hit_arglo) arg_q[31:0] <= pwdata;
      if (hit_arghi) arg_q[PW-1:32] <= pwdata[PW-33:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // position counter, home and mark

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q  <= '0;
      mark_q <= '0;
    end else if (ce) begin
      if (cmd_go & cmd == CMD_SET_HOME & ~run_q)
        pos_q <= '0;
      else if (finish & after_q == 2'h1)
        pos_q <= '0;
      else if (do_step)
        pos_q <= step_pos(pos_q, step_cw);
      if (cmd_go & cmd == CMD_SET_MARK)
        mark_q <= pos_q;
      else if (finish & after_q == 2'h2)
        mark_q <= pos_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // move control

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      run_q     <= 1'b0;
      target_q  <= '0;
      dir_q     <= 1'b1;
      stop_en_q <= 1'b0;
      endless_q <= 1'b0;
      after_q   <= 2'h0;
      tmr_q     <= 32'h0;
      stopped_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_any) begin
            state_q   <= ST_WAIT;
            run_q     <= 1'b1;
            target_q  <= new_tgt;
            dir_q     <= new_dir;
            stop_en_q <= new_stop;
            endless_q <= start_free;
            after_q   <= cmd == CMD_PIN_CCWZ ? 2'h1 :
                         cmd == CMD_PIN_CWM ? 2'h2 : 2'h0;
            tmr_q     <= 32'h0;
            stopped_q <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (finish) begin
            state_q   <= ST_IDLE;
            run_q     <= 1'b0;
            stopped_q <= pin_hit;
          end else if (do_step) begin
            state_q <= ST_STEP;
          end else begin
            tmr_q <= tmr_q - 32'h1;
          end
        end
        ST_STEP: begin
          // a stop command landing in this cycle must not be lost
          if (finish) begin
            state_q   <= ST_IDLE;
            run_q     <= 1'b0;
            stopped_q <= 1'b0;
          end else begin
            state_q <= ST_WAIT;
            tmr_q   <= rate_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse input edge detect, read snapshot and read data

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_in_q <= 1'b1;
      snap_q    <= '0;
      prdata_q  <= 32'h0;
    end else if (ce) begin
      step_in_q <= step_or_ccw_stop_input;
      if (rd_en & paddr == `OFS_POS_LO)
        snap_q <= pos_q;
      if (rd_en) begin
        unique case (1'b1)
          hit_ctrl:                prdata_q <= ctrl_q;
          hit_rate:                prdata_q <= rate_q;
          hit_arglo:               prdata_q <= arg_q[31:0];
          hit_arghi:               prdata_q <= {16'h0, arg_q[PW-1:32]};
          paddr == `OFS_STATUS:    prdata_q <= {29'h0, stopped_q,
                                                pulse_mode, run_q};
          paddr == `OFS_POS_LO:    prdata_q <= pos_q[31:0];
          paddr == `OFS_POS_HI:    prdata_q <= sext(snap_q);
          paddr == `OFS_MARK_LO:   prdata_q <= mark_q[31:0];
          paddr == `OFS_MARK_HI:   prdata_q <= sext(mark_q);
          default:                 prdata_q <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign cif.step = do_step & ce;
  assign cif.cw   = step_cw;
  assign cif.mode = mode;
  assign {coil_one, coil_two, coil_three, coil_four} = cif.coils;
  assign busy_n = ~run_q;
  assign prdata = prdata_q;

  a_busy_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & start_any) |=> !busy_n)
    else $error("busy not raised at move start");

  a_no_overshoot: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & run_q & ~endless_q & arrived) |=> pos_q == $past(pos_q))
    else $error("position moved after arrival");

  a_count_cw: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & do_step & step_cw & !(cmd_go & cmd == CMD_SET_HOME) & !finish)
      |=> pos_q == $past(pos_q) + POS_ONE)
    else $error("clockwise step did not increment");

  a_stop_ends: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & run_q & tick & pin_hit) |=> !run_q)
    else $error("stop input did not end move");

  a_mark_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & cmd_go & cmd == CMD_SET_MARK & !do_step & !finish)
      |=> pos_q == $past(pos_q))
    else $error("set mark changed position");

  a_pulse_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & pulse_fall) |=> cif.coils != $past(cif.coils))
    else $error("pulse edge gave no step");

  a_set_home: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & cmd_go & cmd == CMD_SET_HOME & !run_q) |=> pos_q == '0)
    else $error("set home did not zero position");

  a_reset_pos: assert property (
    @(posedge pclk)
    $rose(presetn) |-> pos_q == '0)
    else $error("position not zero after reset");

  a_count_ccw: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & do_step & !step_cw & !(cmd_go & cmd == CMD_SET_HOME) & !finish)
      |=> pos_q == $past(pos_q) - POS_ONE)
    else $error("counter-clockwise step did not decrement");

  a_stop_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce & run_q & cmd_go & cmd == CMD_STOP) |=> busy_n)
    else $error("stop command left the move running");

endmodule : stepper_seq

// ---- verif/stop_pin_model.sv ----
// switches and pull-ups on the two shared stop and step inputs
`timescale 1ns/100ps
module stop_pin_model (
  input  wire logic ccw_pull,
  input  wire logic cw_pull,
  output logic      step_or_ccw_stop_input,
  output logic      direction_or_cw_stop_input
);
  // a closed switch grounds the pin; an open one leaves the pull-up high
  assign step_or_ccw_stop_input     = ccw_pull ? 1'b0 : 1'b1;
  assign direction_or_cw_stop_input = cw_pull ? 1'b0 : 1'b1;
endmodule : stop_pin_model

// ---- verif/unipolar_stepper_sequencer_tb_top.sv ----
// self-checking bench for the stepper sequencer
`timescale 1ns/100ps
`include "stepper_regs.svh"
module unipolar_stepper_sequencer_tb_top
  import stepper_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, ccw_pull, cw_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, busy_n, c1, c2, c3, c4;
  wire logic   step_in, dir_in;
  logic [3:0]  half_t [8] = '{4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
  logic [3:0]  prev_v = 4'h0;
  longint      m_pos = 0;
  int          m_dir = 1, m_idx = 0, m_mode = 0, m_steps = 0;
  int          fail_count = 0, n_tests = 0;
  bit          m_sync = 1, m_quiet = 1; // idle paint after reset is no step

  stepper_seq dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_or_ccw_stop_input(step_in), .direction_or_cw_stop_input(dir_in),
    .coil_one(c1), .coil_two(c2), .coil_three(c3), .coil_four(c4),
    .busy_n(busy_n));
  stop_pin_model pins (.ccw_pull(ccw_pull), .cw_pull(cw_pull),
    .step_or_ccw_stop_input(step_in), .direction_or_cw_stop_input(dir_in));

  ////////////////////////////////////////////////////////////////
  // reference model: coil tables and position counter
  function automatic int tlen();
    tlen = (m_mode == 2) ? 8 : 4;
  endfunction : tlen
  function automatic logic [3:0] pat(input int k);
    pat = (m_mode == 2) ? half_t[k] : half_t[2 * k + (m_mode == 0)];
  endfunction : pat

  task automatic check(input string what, input logic [63:0] got,
                       input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // each coil change is one step; the first after a mode change resyncs
  always @(posedge pclk) begin
    if (presetn === 1'b1 && {c1, c2, c3, c4} !== prev_v) begin
      prev_v = {c1, c2, c3, c4};
      if (!m_quiet) begin
        m_pos += m_dir;
        m_steps++;
        if (m_sync) begin
          for (int k = 0; k < tlen(); k++) if (pat(k) === prev_v) m_idx = k;
          m_sync = 0;
        end else begin
          m_idx = (m_idx + m_dir + tlen()) % tlen();
          check("coils", prev_v, pat(m_idx));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb master: hold the request until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic arg(input longint v);
    apb(`OFS_ARG_LO, 1'b1, v[31:0]);
    apb(`OFS_ARG_HI, 1'b1, {16'h0000, v[47:32]});
  endtask : arg

  task automatic cpos(input longint e);
    logic [31:0] lo;
    apb(`OFS_POS_LO, 1'b0, 32'h0);
    lo = rd;
    apb(`OFS_POS_HI, 1'b0, 32'h0);
    check("position", {{16{rd[15]}}, rd[15:0], lo}, e);
  endtask : cpos

  // mode changes may repaint the coils, so the monitor looks away
  task automatic set_ctrl(input int v);
    m_quiet = 1;
    apb(`OFS_CTRL, 1'b1, v);
    repeat (3) @(posedge pclk);
    m_mode = v % 4;
    m_quiet = 0;
    m_sync = 1;
  endtask : set_ctrl

  // start a move; pin 1 grounds the ccw stop, pin 2 the cw stop
  task automatic mv(input cmd_t c, input int dir, input int pin);
    int n;
    m_dir = dir;
    m_steps = 0;
    apb(`OFS_CMD, 1'b1, {28'h0000000, c});
    repeat (3) @(posedge pclk);
    check("busy", busy_n, 1'b0);
    n = 0;
    while (pin != 0 && m_steps < 3 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (pin != 0) ccw_pull <= (pin == 1);
    if (pin != 0) cw_pull <= (pin == 2);
    n = 0;
    while (busy_n !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    check("ready", busy_n, 1'b1);
    ccw_pull <= 1'b0;
    cw_pull  <= 1'b0;
  endtask : mv

  // one step pulse; edges spaced by half the minimum outside gap
  task automatic pulse(input int dir);
    m_dir = dir ? 1 : -1;
    cw_pull <= !dir;
    repeat (`STEP_GAP_CYC / 2) @(posedge pclk);
    ccw_pull <= 1'b1;
    repeat (`STEP_GAP_CYC / 2) @(posedge pclk);
    ccw_pull <= 1'b0;
  endtask : pulse

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    finish_test();
  end

  initial begin
    longint t;
    int     st;
    {presetn, psel, penable, pwrite, ccw_pull, cw_pull} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(21781));
    repeat (2) @(posedge pclk);
    // looked at while reset still holds, when the outputs have settled
    check("coils", {c1, c2, c3, c4}, 4'h0);
    check("busy", busy_n, 1'b1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`OFS_CTRL, 1'b0, 32'h0);
    check("ctrl", rd, `CTRL_RESET);
    apb(`OFS_RATE, 1'b0, 32'h0);
    check("rate", rd, `RATE_RESET);
    cpos(0);
    apb(`OFS_RATE, 1'b1, 32'h4);
    $display("test reset done");
    // each table forwards then backwards, net one step per mode
    for (int md = 0; md < 3; md++) begin
      set_ctrl(md);
      t = 3 + int'($urandom % 6);
      arg(t);
      mv(CMD_REL, 1, 0);
      check("steps", m_steps, t);
      arg(1 - t);
      mv(CMD_REL, -1, 0);
      cpos(m_pos);
    end
    $display("test tables done");
    t = -3 - int'($urandom % 10);
    arg(t);
    mv(CMD_ABS, -1, 0);
    cpos(t);
    apb(`OFS_CMD, 1'b1, {28'h0000000, CMD_SET_HOME});
    m_pos = 0;
    cpos(0);
    arg(5);
    mv(CMD_REL, 1, 0);
    apb(`OFS_CMD, 1'b1, {28'h0000000, CMD_SET_MARK});
    cpos(5);
    arg(4);
    mv(CMD_REL, 1, 0);
    mv(CMD_MARK, -1, 0);
    cpos(5);
    mv(CMD_HOME, -1, 0);
    st = m_steps;
    arg(5);
    mv(CMD_REL, 1, 0);
    arg(0);
    mv(CMD_ABS, -1, 0);
    check("steps", m_steps, st);
    cpos(0);
    $display("test home and mark done");
    // a stop command cuts a long relative move short
    m_dir = 1;
    arg(1000);
    apb(`OFS_CMD, 1'b1, {28'h0000000, CMD_REL});
    repeat (30) @(posedge pclk);
    apb(`OFS_CMD, 1'b1, {28'h0000000, CMD_STOP});
    @(posedge pclk);
    check("stop busy", busy_n, 1'b1);
    cpos(m_pos);
    $display("test stop command done");
    arg(40);
    mv(CMD_ABS_STOP, 1, 1);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    check("stop flag", rd[2], 1'b1);
    check("ended early", m_pos < 40, 1'b1);
    ccw_pull <= 1'b1;
    mv(CMD_ABS, 1, 0);
    cpos(40);
    for (int c = 8; c <= 12; c++) begin
      arg(c == 8 ? m_pos + 100 : 100);
      mv(cmd_t'(c), c == 11 ? -1 : 1, c == 11 ? 1 : 2);
      if (c == 11) m_pos = 0;
      if (c == 12) apb(`OFS_MARK_LO, 1'b0, 32'h0);
      if (c == 12) check("mark", rd, m_pos[31:0]);
      cpos(m_pos);
    end
    $display("test stop pins done");
    apb(12'h030, 1'b0, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("slave error", err, 1'b1);
    set_ctrl(4);
    m_steps = 0;
    for (int i = 0; i < 4; i++) pulse(i < 2);
    check("pulses", m_steps, 4);
    cpos(m_pos);
    $display("test pulse mode done");
    finish_test();
  end
endmodule : unipolar_stepper_sequencer_tb_top
